/* rtl/bbn_pkg.sv */
// Shared constants, field layouts and carrier types of the bridge bus-number and I/O window block.
package bbn_pkg;
    // Configuration byte offsets of the registers held here.
    localparam logic [7:0] OFF_HDR_TYPE = 8'h0E;
    localparam logic [7:0] OFF_UP_BUS = 8'h18;
    localparam logic [7:0] OFF_DOWN_BUS = 8'h19;
    localparam logic [7:0] OFF_HIGH_BUS = 8'h1A;
    localparam logic [7:0] OFF_LAT_COUNT = 8'h1B;
    localparam logic [7:0] OFF_IO_BOTTOM = 8'h1C;
    localparam logic [7:0] OFF_IO_TOP = 8'h1D;

    // Doubleword index and byte lane of each register.
    localparam logic [5:0] DW_0C = OFF_HDR_TYPE[7:2];
    localparam logic [5:0] DW_18 = OFF_UP_BUS[7:2];
    localparam logic [5:0] DW_1C = OFF_IO_BOTTOM[7:2];
    localparam logic [1:0] LANE_HDR = OFF_HDR_TYPE[1:0];
    localparam logic [1:0] LANE_UP = OFF_UP_BUS[1:0];
    localparam logic [1:0] LANE_DOWN = OFF_DOWN_BUS[1:0];
    localparam logic [1:0] LANE_HIGH = OFF_HIGH_BUS[1:0];
    localparam logic [1:0] LANE_LAT = OFF_LAT_COUNT[1:0];
    localparam logic [1:0] LANE_IO_BOTTOM = OFF_IO_BOTTOM[1:0];
    localparam logic [1:0] LANE_IO_TOP = OFF_IO_TOP[1:0];

    // Fixed values and reset values.
    localparam logic [7:0] HDR_TYPE_BRIDGE = 8'h01;
    localparam logic [3:0] IO_DECODE_32 = 4'h1;
    localparam logic [7:0] RST_BUS = 8'h00;
    localparam logic [7:0] RST_LAT = 8'h00;
    localparam logic [3:0] RST_IO_NIB = 4'h0;
    localparam logic [11:0] IO_LOW_BOTTOM = 12'h000;
    localparam logic [11:0] IO_LOW_TOP = 12'hFFF;

    // Field positions inside the I/O bytes.
    localparam int IO_NIB_MSB = 7;
    localparam int IO_NIB_LSB = 4;

    // Configuration access request and answer.
    typedef struct packed {
        logic valid;
        logic write;
        logic [5:0] dw_index;
        logic [3:0] be_n;
        logic [31:0] wdata;
    } bbn_cfg_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } bbn_cfg_rsp_t;

    // A Type 1 configuration request seen on one side.
    typedef struct packed {
        logic valid;
        logic [7:0] bus;
        logic special;
    } bbn_t1_req_t;

    // Decision for a primary-side Type 1 request.
    typedef struct packed {
        logic claim;
        logic to_type0;
        logic to_special;
        logic pass_type1;
    } bbn_down_dec_t;

    // Decision for a secondary-side Type 1 request.
    typedef struct packed {
        logic to_special;
        logic pass_up;
    } bbn_up_dec_t;

    typedef enum logic [1:0] {
        LAT_IDLE,
        LAT_RUN,
        LAT_EXPIRED
    } bbn_lat_state_t;
endpackage : bbn_pkg

/* rtl/bbn_bus_decode.sv */
// Bus-number decoder for Type 1 configuration requests on both sides of the bridge.
module bbn_bus_decode (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] up_bus,
    input wire logic [7:0] down_bus,
    input wire logic [7:0] high_bus,
    input wire bbn_pkg::bbn_t1_req_t pri_req,
    input wire bbn_pkg::bbn_t1_req_t sec_req,
    output bbn_pkg::bbn_down_dec_t pri_dec,
    output bbn_pkg::bbn_up_dec_t sec_dec
);
    import bbn_pkg::*;

    bbn_down_dec_t pri_d, pri_q;
    bbn_up_dec_t sec_d, sec_q;

    // True when a bus number lies in the range owned by the far side.
    function automatic logic in_range(input logic [7:0] bus, input logic [7:0] lo,
                                      input logic [7:0] hi);
        in_range = (bus >= lo) && (bus <= hi);
    endfunction : in_range

    // Decode both sides from the live bus numbers.
    always_comb begin
        pri_d = '0;
        sec_d = '0;
        if (pri_req.valid && in_range(pri_req.bus, down_bus, high_bus)) begin
            pri_d.claim = 1'b1;
            if (pri_req.bus == down_bus) begin
                pri_d.to_special = pri_req.special;
                pri_d.to_type0 = !pri_req.special;
            end else begin
                pri_d.pass_type1 = 1'b1;
            end
        end
        if (sec_req.valid) begin
            // A request aimed at a bus behind us is not sent upstream at all.
            if (sec_req.special && sec_req.bus == up_bus) begin
                sec_d.to_special = 1'b1;
            end else if (!in_range(sec_req.bus, down_bus, high_bus)) begin
                sec_d.pass_up = 1'b1;
            end
        end
    end

    // Decisions are held for one cycle after the request is seen.
    always_ff @(posedge clk) begin
        if (srst) begin
            pri_q <= '0;
            sec_q <= '0;
        end else begin
            pri_q <= pri_d;
            sec_q <= sec_d;
        end
    end

    assign pri_dec = pri_q;
    assign sec_dec = sec_q;
endmodule : bbn_bus_decode

/* rtl/bbn_lat_timer.sv */
// Secondary-side master latency timer with its end-of-tenure request.
module bbn_lat_timer #(
    parameter int LAT_W = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [LAT_W-1:0] lat_count,
    input wire logic frame_start,
    input wire logic master_active,
    input wire logic grant,
    input wire logic data_xfer,
    input wire logic mwi,
    output logic expired,
    output logic end_req
);
    import bbn_pkg::*;

    if (LAT_W < 1 || LAT_W > 8) begin : g_chk
        $error("LAT_W must be 1 to 8");
    end

    bbn_lat_state_t state_d, state_q;
    logic [LAT_W-1:0] cnt_d, cnt_q;
    logic first_d, first_q;
    logic end_d, end_q;
    logic exp_d, exp_q;

    // Count clocks from our frame assertion; one clock per step.
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        first_d = first_q;
        case (state_q)
            LAT_IDLE: begin
                first_d = 1'b0;
                if (frame_start) begin
                    cnt_d = lat_count;
                    state_d = (lat_count == '0) ? LAT_EXPIRED : LAT_RUN;
                end
            end
            LAT_RUN: begin
                cnt_d = cnt_q - 1'b1;
                if (cnt_q == {{(LAT_W-1){1'b0}}, 1'b1}) begin
                    state_d = LAT_EXPIRED;
                end
            end
            LAT_EXPIRED: begin
                cnt_d = '0;
            end
            default: begin
                state_d = LAT_IDLE;
            end
        endcase
        if (state_q != LAT_IDLE && data_xfer) begin
            first_d = 1'b1;
        end
        if (!master_active) begin
            state_d = LAT_IDLE;
            first_d = 1'b0;
        end
        // With a zero count the tenure ends after one data phase, unless MWI runs.
        if (lat_count == '0) begin
            end_d = master_active && !grant && first_q && !mwi;
        end else begin
            end_d = master_active && !grant && state_q == LAT_EXPIRED;
        end
        // Expiry is registered from the next state so the output leaves a flop, same timing.
        exp_d = (state_d == LAT_EXPIRED);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= LAT_IDLE;
            cnt_q <= '0;
            first_q <= 1'b0;
            end_q <= 1'b0;
            exp_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            first_q <= first_d;
            end_q <= end_d;
            exp_q <= exp_d;
        end
    end

    assign expired = exp_q;
    assign end_req = end_q;
endmodule : bbn_lat_timer

/* rtl/bbn_bridge_cfg_regs.sv */
// Bridge bus-number, secondary latency and I/O window configuration registers.
// How it works
// - Header type byte always reads 01h, the bridge layout code.
// - Upstream bus number, reset zero, steers secondary Type 1 upstream handling.
// - Downstream bus number, reset zero, steers primary Type 1 claim and conversion.
// - Buses above downstream up to highest-behind pass downstream still as Type 1.
// - Latency count, reset zero, counts clocks from our secondary frame start.
// - Zero count and grant removed ends after first transfer, except MWI.
// - Low nibbles of I/O bottom and top bytes read 1h and ignore writes.
// - I/O bottom bits 15:12 come from its upper nibble, low twelve bits zero.
// - I/O top bits 15:12 from its upper nibble, low twelve bits all ones.
// - I/O address bits 31:16 come from separate upper-half registers.
// - I/O transaction is forwarded when its address lies between bottom and top.
module bbn_bridge_cfg_regs #(
    parameter int LAT_W = 8
) (
    input wire logic CLOCK,
    input wire logic SRST,
    input wire bbn_pkg::bbn_cfg_req_t CFG_REQ,
    output bbn_pkg::bbn_cfg_rsp_t CFG_RSP,
    input wire bbn_pkg::bbn_t1_req_t PRI_T1_REQ,
    output bbn_pkg::bbn_down_dec_t PRI_T1_DEC,
    input wire bbn_pkg::bbn_t1_req_t SEC_T1_REQ,
    output bbn_pkg::bbn_up_dec_t SEC_T1_DEC,
    input wire logic SEC_FRAME_START,
    input wire logic SEC_MASTER_ACTIVE,
    input wire logic SEC_GRANT,
    input wire logic SEC_DATA_XFER,
    input wire logic SEC_MWI,
    output logic SEC_LAT_EXPIRED,
    output logic SEC_END_REQ,
    input wire logic [15:0] IO_BOTTOM_UPPER,
    input wire logic [15:0] IO_TOP_UPPER,
    input wire logic IO_ADDR_VALID,
    input wire logic [31:0] IO_ADDR,
    output logic IO_FORWARD,
    output logic [31:0] IO_WINDOW_BASE,
    output logic [31:0] IO_WINDOW_LIMIT,
    output logic [7:0] UPSTREAM_BUS,
    output logic [7:0] DOWNSTREAM_BUS,
    output logic [7:0] HIGHEST_BUS,
    output logic [LAT_W-1:0] LATENCY_COUNT
);
    import bbn_pkg::*;

    if (LAT_W != 8) begin : g_chk
        $error("LAT_W must be 8, the width of the latency byte");
    end

    // Register state.
    logic [7:0] up_bus_d, up_bus_q;
    logic [7:0] down_bus_d, down_bus_q;
    logic [7:0] high_bus_d, high_bus_q;
    logic [7:0] lat_d, lat_q;
    logic [3:0] io_bot_nib_d, io_bot_nib_q;
    logic [3:0] io_top_nib_d, io_top_nib_q;

    // Access answer state.
    bbn_cfg_rsp_t rsp_d, rsp_q;

    // Window state.
    logic [31:0] base_d, base_q;
    logic [31:0] limit_d, limit_q;
    logic fwd_d, fwd_q;
    logic [31:0] base_now;
    logic [31:0] limit_now;

    logic wr_18;
    logic wr_1c;

    // Picks one byte lane out of a doubleword.
    function automatic logic [7:0] lane_byte(input logic [31:0] data, input logic [1:0] lane);
        lane_byte = data[{lane, 3'b000} +: 8];
    endfunction : lane_byte

    // Merges a byte into a register when its active-low lane enable is set.
    function automatic logic [7:0] lane_merge(input logic [7:0] old_val,
                                              input bbn_cfg_req_t req,
                                              input logic [1:0] lane);
        if (!req.be_n[lane]) begin
            lane_merge = lane_byte(req.wdata, lane);
        end else begin
            lane_merge = old_val;
        end
    endfunction : lane_merge

    assign wr_18 = CFG_REQ.valid && CFG_REQ.write && CFG_REQ.dw_index == DW_18;
    assign wr_1c = CFG_REQ.valid && CFG_REQ.write && CFG_REQ.dw_index == DW_1C;

    // Writable fields take only their own enabled lanes.
    always_comb begin
        logic [7:0] io_bot_byte;
        logic [7:0] io_top_byte;
        io_bot_byte = lane_merge({io_bot_nib_q, IO_DECODE_32}, CFG_REQ, LANE_IO_BOTTOM);
        io_top_byte = lane_merge({io_top_nib_q, IO_DECODE_32}, CFG_REQ, LANE_IO_TOP);
        up_bus_d = up_bus_q;
        down_bus_d = down_bus_q;
        high_bus_d = high_bus_q;
        lat_d = lat_q;
        io_bot_nib_d = io_bot_nib_q;
        io_top_nib_d = io_top_nib_q;
        if (wr_18) begin
            up_bus_d = lane_merge(up_bus_q, CFG_REQ, LANE_UP);
            down_bus_d = lane_merge(down_bus_q, CFG_REQ, LANE_DOWN);
            high_bus_d = lane_merge(high_bus_q, CFG_REQ, LANE_HIGH);
            lat_d = lane_merge(lat_q, CFG_REQ, LANE_LAT);
        end
        if (wr_1c) begin
            // Only the upper nibbles are stored; the low nibbles are fixed.
            io_bot_nib_d = io_bot_byte[IO_NIB_MSB:IO_NIB_LSB];
            io_top_nib_d = io_top_byte[IO_NIB_MSB:IO_NIB_LSB];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            up_bus_q <= RST_BUS;
            down_bus_q <= RST_BUS;
            high_bus_q <= RST_BUS;
            lat_q <= RST_LAT;
            io_bot_nib_q <= RST_IO_NIB;
            io_top_nib_q <= RST_IO_NIB;
        end else begin
            up_bus_q <= up_bus_d;
            down_bus_q <= down_bus_d;
            high_bus_q <= high_bus_d;
            lat_q <= lat_d;
            io_bot_nib_q <= io_bot_nib_d;
            io_top_nib_q <= io_top_nib_d;
        end
    end

    // Read data and acknowledge, one cycle after the request; other lanes read zero.
    always_comb begin
        rsp_d = '0;
        rsp_d.ack = CFG_REQ.valid;
        if (CFG_REQ.valid && !CFG_REQ.write) begin
            case (CFG_REQ.dw_index)
                DW_0C: begin
                    rsp_d.rdata[{LANE_HDR, 3'b000} +: 8] = HDR_TYPE_BRIDGE;
                end
                DW_18: begin
                    rsp_d.rdata[{LANE_UP, 3'b000} +: 8] = up_bus_q;
                    rsp_d.rdata[{LANE_DOWN, 3'b000} +: 8] = down_bus_q;
                    rsp_d.rdata[{LANE_HIGH, 3'b000} +: 8] = high_bus_q;
                    rsp_d.rdata[{LANE_LAT, 3'b000} +: 8] = lat_q;
                end
                DW_1C: begin
                    rsp_d.rdata[{LANE_IO_BOTTOM, 3'b000} +: 8] = {io_bot_nib_q, IO_DECODE_32};
                    rsp_d.rdata[{LANE_IO_TOP, 3'b000} +: 8] = {io_top_nib_q, IO_DECODE_32};
                end
                default: begin
                    rsp_d.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    // Window bounds: 4 KB aligned bottom, top padded with ones to the end of its 4 KB step.
    assign base_now = {IO_BOTTOM_UPPER, io_bot_nib_q, IO_LOW_BOTTOM};
    assign limit_now = {IO_TOP_UPPER, io_top_nib_q, IO_LOW_TOP};

    // An empty window (top below bottom) forwards nothing, which is the safe reading.
    always_comb begin
        base_d = base_now;
        limit_d = limit_now;
        fwd_d = IO_ADDR_VALID && IO_ADDR >= base_now && IO_ADDR <= limit_now;
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            base_q <= '0;
            limit_q <= {16'h0000, RST_IO_NIB, IO_LOW_TOP};
            fwd_q <= 1'b0;
        end else begin
            base_q <= base_d;
            limit_q <= limit_d;
            fwd_q <= fwd_d;
        end
    end

    // Type 1 routing uses the live bus numbers; software must set them first.
    bbn_bus_decode u_decode (
        .clk(CLOCK),
        .srst(SRST),
        .up_bus(up_bus_q),
        .down_bus(down_bus_q),
        .high_bus(high_bus_q),
        .pri_req(PRI_T1_REQ),
        .sec_req(SEC_T1_REQ),
        .pri_dec(PRI_T1_DEC),
        .sec_dec(SEC_T1_DEC)
    );

    // The timer sees the programmed count directly: the countdown reloads it at the next frame, but the zero-count end rule follows a rewrite at once.
    bbn_lat_timer #(
        .LAT_W(LAT_W)
    ) u_timer (
        .clk(CLOCK),
        .srst(SRST),
        .lat_count(lat_q[LAT_W-1:0]),
        .frame_start(SEC_FRAME_START),
        .master_active(SEC_MASTER_ACTIVE),
        .grant(SEC_GRANT),
        .data_xfer(SEC_DATA_XFER),
        .mwi(SEC_MWI),
        .expired(SEC_LAT_EXPIRED),
        .end_req(SEC_END_REQ)
    );

    assign CFG_RSP = rsp_q;
    assign IO_FORWARD = fwd_q;
    assign IO_WINDOW_BASE = base_q;
    assign IO_WINDOW_LIMIT = limit_q;
    assign UPSTREAM_BUS = up_bus_q;
    assign DOWNSTREAM_BUS = down_bus_q;
    assign HIGHEST_BUS = high_bus_q;
    assign LATENCY_COUNT = lat_q[LAT_W-1:0];
endmodule : bbn_bridge_cfg_regs

/* testbench/bbn_bridge_cfg_regs_properties.sv */
// Concurrent checks on the ports of the bridge configuration register block.
module bbn_bridge_cfg_regs_properties #(
    parameter int LAT_W = 8
) (
    input wire logic CLOCK,
    input wire logic SRST,
    input wire bbn_pkg::bbn_cfg_req_t CFG_REQ,
    input wire bbn_pkg::bbn_cfg_rsp_t CFG_RSP,
    input wire bbn_pkg::bbn_t1_req_t PRI_T1_REQ,
    input wire bbn_pkg::bbn_down_dec_t PRI_T1_DEC,
    input wire bbn_pkg::bbn_t1_req_t SEC_T1_REQ,
    input wire bbn_pkg::bbn_up_dec_t SEC_T1_DEC,
    input wire logic SEC_FRAME_START,
    input wire logic SEC_MASTER_ACTIVE,
    input wire logic SEC_GRANT,
    input wire logic SEC_DATA_XFER,
    input wire logic SEC_MWI,
    input wire logic SEC_LAT_EXPIRED,
    input wire logic SEC_END_REQ,
    input wire logic IO_ADDR_VALID,
    input wire logic [31:0] IO_ADDR,
    input wire logic IO_FORWARD,
    input wire logic [31:0] IO_WINDOW_BASE,
    input wire logic [31:0] IO_WINDOW_LIMIT,
    input wire logic [7:0] UPSTREAM_BUS,
    input wire logic [7:0] DOWNSTREAM_BUS,
    input wire logic [7:0] HIGHEST_BUS,
    input wire logic [LAT_W-1:0] LATENCY_COUNT
);
    timeunit 1ns;
    timeprecision 1ps;
    import bbn_pkg::*;

    // Every check belongs to the single clock domain and is quiet during reset.
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);

    a_cfg_ack_pulse: assert property (!$past(SRST) |-> CFG_RSP.ack == $past(CFG_REQ.valid))
        else $error("config answer not one cycle after request");
    a_hdr_type_const: assert property (CFG_REQ.valid && !CFG_REQ.write && CFG_REQ.dw_index == DW_0C
        |=> CFG_RSP.rdata[23:16] == HDR_TYPE_BRIDGE) else $error("header byte wrong");
    a_io_nib_fixed: assert property (CFG_REQ.valid && !CFG_REQ.write && CFG_REQ.dw_index == DW_1C
        |=> CFG_RSP.rdata[3:0] == IO_DECODE_32 && CFG_RSP.rdata[11:8] == IO_DECODE_32)
        else $error("io decode nibble wrong");
    a_up_lane_write: assert property (CFG_REQ.valid && CFG_REQ.write && CFG_REQ.dw_index == DW_18
        && !CFG_REQ.be_n[LANE_UP] |=> UPSTREAM_BUS == $past(CFG_REQ.wdata[7:0]))
        else $error("upstream bus not written");
    a_pri_claim: assert property (PRI_T1_REQ.valid && PRI_T1_REQ.bus >= DOWNSTREAM_BUS
        && PRI_T1_REQ.bus <= HIGHEST_BUS |=> PRI_T1_DEC.claim) else $error("in-range bus not claimed");
    a_pri_type0: assert property (PRI_T1_REQ.valid && PRI_T1_REQ.bus == DOWNSTREAM_BUS
        && !PRI_T1_REQ.special |=> PRI_T1_DEC.to_type0 && !PRI_T1_DEC.pass_type1)
        else $error("downstream bus not turned to type 0");
    a_sec_special: assert property (SEC_T1_REQ.valid && SEC_T1_REQ.special
        && SEC_T1_REQ.bus == UPSTREAM_BUS |=> SEC_T1_DEC.to_special && !SEC_T1_DEC.pass_up)
        else $error("upstream special cycle not converted");
    a_lat_two_run: assert property (SEC_FRAME_START && LATENCY_COUNT == 8'h02 && !SEC_LAT_EXPIRED
        |-> !SEC_LAT_EXPIRED [*3] ##1 SEC_LAT_EXPIRED) else $error("timer of two misfired");
    a_zero_end: assert property (LATENCY_COUNT == 8'h00 && SEC_MASTER_ACTIVE && !SEC_GRANT
        && !SEC_MWI && SEC_DATA_XFER |-> ##[1:2] SEC_END_REQ) else $error("zero count did not end");
    a_io_forward: assert property (IO_ADDR_VALID |=> IO_FORWARD ==
        ($past(IO_ADDR) >= IO_WINDOW_BASE && $past(IO_ADDR) <= IO_WINDOW_LIMIT))
        else $error("io forward decision wrong");
endmodule : bbn_bridge_cfg_regs_properties

/* testbench/bbn_cfg_host.sv */
// Configuration host model issuing single accesses on the primary side.
module bbn_cfg_host (
    input wire logic CLOCK,
    output bbn_pkg::bbn_cfg_req_t CFG_REQ,
    input wire bbn_pkg::bbn_cfg_rsp_t CFG_RSP
);
    timeunit 1ns;
    timeprecision 1ps;
    import bbn_pkg::*;

    initial CFG_REQ = '0;

    // The request stands for one edge and the answer is taken a cycle later; idle fields are
    // inverted so the block cannot lean on stale values.
    task automatic access(input logic wr, input logic [5:0] dw, input logic [3:0] be_n,
                          input logic [31:0] wd, output logic ack, output logic [31:0] rd);
        @(negedge CLOCK);
        CFG_REQ <= '{1'b1, wr, dw, be_n, wd};
        @(negedge CLOCK);
        ack = CFG_RSP.ack;
        rd = CFG_RSP.rdata;
        CFG_REQ <= '{1'b0, ~wr, ~dw, ~be_n, ~wd};
    endtask : access
endmodule : bbn_cfg_host

/* testbench/bbn_bridge_cfg_regs_bench.sv */
// Self-checking bench for the bridge bus-number, latency and I/O window registers.
module bbn_bridge_cfg_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import bbn_pkg::*;
    logic clock = 1'b0;
    logic srst = 1'b1;
    bbn_cfg_req_t cfg_req;
    bbn_cfg_rsp_t cfg_rsp;
    bbn_t1_req_t pri_req = '0;
    bbn_t1_req_t sec_req = '0;
    bbn_down_dec_t pri_dec;
    bbn_up_dec_t sec_dec;
    logic frame_start = 0, active = 0, grant = 0, xfer = 0, mwi = 0, io_valid = 0;
    logic lat_exp, end_req, io_fwd;
    logic [15:0] bot_up = 16'h0000, top_up = 16'h0000;
    logic [31:0] io_addr = 32'h0, win_base, win_limit;
    logic [7:0] up_bus, down_bus, high_bus, lat_count;
    int errors = 0, check_count = 0, cycles = 0;
    // Each entry: bus, special, primary decision, secondary decision, with up 3, down 5, high 9.
    logic [14:0] t1_tab [7] = '{{8'h05, 5'b01100, 2'b00}, {8'h05, 5'b11010, 2'b00},
        {8'h09, 5'b01001, 2'b00}, {8'h04, 5'b00000, 2'b01}, {8'h0A, 5'b00000, 2'b01},
        {8'h03, 5'b10000, 2'b10}, {8'h03, 5'b00000, 2'b01}};
    logic [32:0] io_tab [5] = '{{32'h00010FFF, 1'b0}, {32'h00011000, 1'b1},
        {32'h00012FFF, 1'b1}, {32'h00013000, 1'b0}, {32'h00021800, 1'b0}};

    always #2 clock = ~clock;

    bbn_cfg_host host (.CLOCK(clock), .CFG_REQ(cfg_req), .CFG_RSP(cfg_rsp));

    bbn_bridge_cfg_regs #(.LAT_W(8)) dut (.CLOCK(clock), .SRST(srst), .CFG_REQ(cfg_req),
        .CFG_RSP(cfg_rsp), .PRI_T1_REQ(pri_req), .PRI_T1_DEC(pri_dec), .SEC_T1_REQ(sec_req),
        .SEC_T1_DEC(sec_dec), .SEC_FRAME_START(frame_start), .SEC_MASTER_ACTIVE(active),
        .SEC_GRANT(grant), .SEC_DATA_XFER(xfer), .SEC_MWI(mwi), .SEC_LAT_EXPIRED(lat_exp),
        .SEC_END_REQ(end_req), .IO_BOTTOM_UPPER(bot_up), .IO_TOP_UPPER(top_up),
        .IO_ADDR_VALID(io_valid), .IO_ADDR(io_addr), .IO_FORWARD(io_fwd),
        .IO_WINDOW_BASE(win_base), .IO_WINDOW_LIMIT(win_limit), .UPSTREAM_BUS(up_bus),
        .DOWNSTREAM_BUS(down_bus), .HIGHEST_BUS(high_bus), .LATENCY_COUNT(lat_count));

    task automatic conclude();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [5:0] dw, input logic [3:0] be_n, input logic [31:0] d);
        logic a;
        logic [31:0] r;
        host.access(1'b1, dw, be_n, d, a, r);
        chk("write ack", 32'h1, {31'h0, a});
    endtask : wr

    task automatic rd(input logic [5:0] dw, input logic [31:0] exp);
        logic a;
        logic [31:0] r;
        host.access(1'b0, dw, 4'h0, 32'h0, a, r);
        chk("read ack", 32'h1, {31'h0, a});
        chk("read data", exp, r);
    endtask : rd

    // A hang is cut short well past the fewer than a hundred cycles the sequence needs.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            conclude();
        end
    end

    initial begin
        repeat (6) @(negedge clock);
        srst = 1'b0;
        rd(6'h03, 32'h00010000);
        rd(6'h06, 32'h00000000);
        rd(6'h07, 32'h00000101);
        chk("limit", 32'h00000FFF, win_limit);
        wr(6'h03, 4'h0, 32'hFFFFFFFF);
        rd(6'h03, 32'h00010000);
        wr(6'h07, 4'h0, 32'hFFFFFFFF);
        rd(6'h07, 32'h0000F1F1);
        wr(6'h08, 4'h0, 32'hFFFFFFFF);
        rd(6'h08, 32'h00000000);
        wr(6'h06, 4'hE, 32'h44332211);
        rd(6'h06, 32'h00000011);
        wr(6'h06, 4'h5, 32'h88776655);
        rd(6'h06, 32'h88006611);
        // Software sets every bus number and the window before any forwarding is relied on.
        wr(6'h06, 4'h0, 32'h02090503);
        chk("buses", 32'h02090503, {lat_count, high_bus, down_bus, up_bus});
        wr(6'h07, 4'hC, 32'h00002010);
        bot_up = 16'h0001;
        top_up = 16'h0001;
        repeat (2) @(negedge clock);
        chk("base", 32'h00011000, win_base);
        chk("limit", 32'h00012FFF, win_limit);
        rd(6'h07, 32'h00002111);
        // Decisions are back to back, one request every cycle.
        foreach (t1_tab[i]) begin
            pri_req = '{1'b1, t1_tab[i][14:7], t1_tab[i][6]};
            sec_req = pri_req;
            @(negedge clock);
            chk("pri dec", {28'h0, t1_tab[i][5:2]}, {28'h0, pri_dec});
            chk("sec dec", {30'h0, t1_tab[i][1:0]}, {30'h0, sec_dec});
        end
        pri_req.valid = 1'b0;
        sec_req.valid = 1'b0;
        foreach (io_tab[i]) begin
            io_addr = io_tab[i][32:1];
            io_valid = 1'b1;
            @(negedge clock);
            chk("forward", {31'h0, io_tab[i][0]}, {31'h0, io_fwd});
        end
        io_valid = 1'b0;
        // Count of two: expiry is seen in the third cycle after the frame start.
        {grant, active, frame_start} = 3'b111;
        @(negedge clock);
        frame_start = 1'b0;
        chk("expired", 32'h0, {31'h0, lat_exp});
        @(negedge clock);
        chk("expired", 32'h0, {31'h0, lat_exp});
        @(negedge clock);
        chk("expired", 32'h1, {31'h0, lat_exp});
        grant = 1'b0;
        @(negedge clock);
        chk("end", 32'h1, {31'h0, end_req});
        active = 1'b0;
        @(negedge clock);
        chk("idle", 32'h0, {30'h0, lat_exp, end_req});
        wr(6'h06, 4'h7, 32'h00000000);
        // Zero count: plain transfer must end, memory write and invalidate must not.
        for (int m = 0; m < 2; m++) begin
            {active, frame_start, mwi} = {2'b11, m[0]};
            @(negedge clock);
            {frame_start, xfer} = 2'b01;
            @(negedge clock);
            xfer = 1'b0;
            @(negedge clock);
            chk("zero end", {31'h0, !m[0]}, {31'h0, end_req});
            {active, mwi} = 2'b00;
            repeat (2) @(negedge clock);
        end
        srst = 1'b1;
        repeat (2) @(negedge clock);
        srst = 1'b0;
        chk("up after reset", 32'h0, {24'h0, up_bus});
        conclude();
    end
endmodule : bbn_bridge_cfg_regs_bench

bind bbn_bridge_cfg_regs bbn_bridge_cfg_regs_properties #(.LAT_W(LAT_W)) props (
    .CLOCK(CLOCK), .SRST(SRST), .CFG_REQ(CFG_REQ), .CFG_RSP(CFG_RSP),
    .PRI_T1_REQ(PRI_T1_REQ), .PRI_T1_DEC(PRI_T1_DEC), .SEC_T1_REQ(SEC_T1_REQ),
    .SEC_T1_DEC(SEC_T1_DEC), .SEC_FRAME_START(SEC_FRAME_START),
    .SEC_MASTER_ACTIVE(SEC_MASTER_ACTIVE), .SEC_GRANT(SEC_GRANT), .SEC_DATA_XFER(SEC_DATA_XFER),
    .SEC_MWI(SEC_MWI), .SEC_LAT_EXPIRED(SEC_LAT_EXPIRED), .SEC_END_REQ(SEC_END_REQ),
    .IO_ADDR_VALID(IO_ADDR_VALID), .IO_ADDR(IO_ADDR), .IO_FORWARD(IO_FORWARD),
    .IO_WINDOW_BASE(IO_WINDOW_BASE), .IO_WINDOW_LIMIT(IO_WINDOW_LIMIT),
    .UPSTREAM_BUS(UPSTREAM_BUS), .DOWNSTREAM_BUS(DOWNSTREAM_BUS), .HIGHEST_BUS(HIGHEST_BUS),
    .LATENCY_COUNT(LATENCY_COUNT));
